// ### cmm_pkg.sv
// package: constants, states and carriers of the cpu memory map decoder
package cmm_pkg;
  // program side
  localparam int          IP_W          = 15;
  localparam int          PROG_AW       = 13;
  localparam int          PROG_DW       = 14;
  localparam logic [14:0] RESET_VECTOR  = 15'h0000;
  localparam logic [14:0] INTR_VECTOR   = 15'h0004;
  localparam int          PAGE_LSB      = 11;
  localparam int          PTR_PROG_BIT  = 15;
  localparam int          STK_DEPTH     = 16;
  localparam logic [4:0]  STK_FULL      = 5'h10;
  // data side
  localparam int          BANK_W        = 5;
  localparam int          LOC_W         = 7;
  localparam int          DADDR_W       = 12;
  localparam logic [6:0]  CORE_LAST     = 7'h0b;
  localparam logic [6:0]  LOC_WIN0      = 7'h00;
  localparam logic [6:0]  LOC_WIN1      = 7'h01;
  localparam logic [6:0]  LOC_IP_LOW    = 7'h02;
  localparam logic [6:0]  LOC_STATUS    = 7'h03;
  localparam logic [6:0]  LOC_PTR0_LO   = 7'h04;
  localparam logic [6:0]  LOC_PTR0_HI   = 7'h05;
  localparam logic [6:0]  LOC_PTR1_LO   = 7'h06;
  localparam logic [6:0]  LOC_PTR1_HI   = 7'h07;
  localparam logic [6:0]  LOC_BANK      = 7'h08;
  localparam logic [6:0]  LOC_WORKING   = 7'h09;
  localparam logic [6:0]  LOC_LATCH_HI  = 7'h0a;
  localparam logic [6:0]  LOC_INT_CTRL  = 7'h0b;
  // status bit positions
  localparam int          ST_C          = 0;
  localparam int          ST_DC         = 1;
  localparam int          ST_Z          = 2;
  localparam int          ST_PD         = 3;
  localparam int          ST_TO         = 4;
  localparam logic [7:0]  STATUS_RESET  = 8'h18;
  // axi4-lite register byte offsets
  localparam logic [7:0]  A_CTRL        = 8'h00;
  localparam logic [7:0]  A_STACK       = 8'h04;
  localparam logic [7:0]  A_IPTR        = 8'h08;
  localparam logic [7:0]  A_CORE        = 8'h0c;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_DECERR   = 2'b11;

  // access sequencer states
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_DATA  = 4'b0010,
    S_PROG1 = 4'b0100,
    S_PROG2 = 4'b1000
  } cmm_state_t;

  // flow request from the execution datapath
  typedef struct packed {
    logic        advance;
    logic        intr_take;
    logic        call;
    logic        ret;
    logic        jump;
    logic [14:0] target;
  } cmm_flow_t;

  // file access request from the execution datapath
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       indirect;
    logic       ptr_sel;
    logic [6:0] file;
    logic [7:0] wdata;
    logic       to_working;
    logic       clear_op;
    logic [2:0] flag_mask;
    logic [2:0] flag_val;
    logic       is_sub;
  } cmm_acc_t;
endpackage : cmm_pkg

// ### cmm_memmap.sv
// cpu memory map decoder: program counter, stack, banking and core registers
// Operation
// - fifteen bit pointer over 32K x 14 space
// - addresses beyond memory wrap into it
// - reset loads 0000h, interrupt loads 0004h
// - pointer high bit 7 selects program memory
// - program read yields low eight bits
// - window writes to program memory ignored
// - program access costs one extra cycle
// - data memory is 32 banks of 128
// - bank order core, peripheral, ram, common
// - twelve core registers in every bank
// - bank select register picks direct bank
// - unimplemented data locations read zero
// - twelve bit address from bank and offset
// - direct or either pointer reaches everything
// - flag-updating ops block status flag writes
// - expiry and sleep flags not software writable
// - sixteen deep stack with overflow/underflow
// - 8192 implemented words, higher addresses alias
// - subtraction carry and digit carry are inverted borrows, zero flag passes as is
// - clear of status sets zero flag only
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cmm_memmap
  import cmm_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // execution datapath
  input  wire cmm_pkg::cmm_flow_t flow,
  input  wire cmm_pkg::cmm_acc_t  acc,
  output logic                    acc_ready,
  output logic                    resp_valid,
  output logic [7:0]              resp_data,
  input  wire logic               wdt_expired,
  input  wire logic               wdt_cleared,
  input  wire logic               sleep_entered,
  // memory arrays
  output logic [12:0]             prog_addr,
  output logic [1:0]              prog_page,
  output logic                    prog_rd,
  input  wire logic [13:0]        prog_rdata,
  output logic [11:0]             data_addr,
  output logic                    data_rd,
  output logic                    data_wr,
  output logic [7:0]              data_wdata,
  input  wire logic [7:0]         data_rdata,
  input  wire logic               data_hit,
  output logic                    soft_reset
);

  // sequencer and core register state
  cmm_state_t   state_q;
  cmm_acc_t     req_q;
  logic [14:0]  ip_q;
  logic [4:0]   bank_q;
  logic [15:0]  ptr0_q, ptr1_q;
  logic [7:0]   status_q, working_q, int_ctrl_q;
  logic [6:0]   latch_hi_q;
  logic [11:0]  daddr_q;
  logic [12:0]  paddr_q;
  logic [14:0]  stack_q [STK_DEPTH];
  logic [4:0]   sp_q;
  logic         ovf_q, unf_q, stk_rst_en_q, soft_reset_q;
  logic [7:0]   resp_data_q;
  logic         resp_valid_q;

  wire  [15:0]  ptr_sel = acc.ptr_sel ? ptr1_q : ptr0_q;
  wire          to_prog = acc.indirect && ptr_sel[PTR_PROG_BIT];
  wire  [11:0]  dir_addr = {bank_q, acc.file};
  wire  [11:0]  new_daddr = acc.indirect ? ptr_sel[11:0] : dir_addr;
  wire          take = acc.valid && (state_q == S_IDLE);
  wire  [6:0]   loc = daddr_q[6:0];
  wire          is_core = (loc <= CORE_LAST);
  wire          done = (state_q == S_DATA) || (state_q == S_PROG2);
  wire          wr_core = (state_q == S_DATA) && req_q.write && is_core;

  logic [7:0] core_rd;
  always_comb begin
    unique case (loc)
      LOC_IP_LOW:   core_rd = ip_q[7:0];
      LOC_STATUS:   core_rd = status_q;
      LOC_PTR0_LO:  core_rd = ptr0_q[7:0];
      LOC_PTR0_HI:  core_rd = ptr0_q[15:8];
      LOC_PTR1_LO:  core_rd = ptr1_q[7:0];
      LOC_PTR1_HI:  core_rd = ptr1_q[15:8];
      LOC_BANK:     core_rd = {3'h0, bank_q};
      LOC_WORKING:  core_rd = working_q;
      LOC_LATCH_HI: core_rd = {1'b0, latch_hi_q};
      LOC_INT_CTRL: core_rd = int_ctrl_q;
      default:      core_rd = 8'h00;
    endcase
  end
  wire  [7:0]   rd_val = (state_q == S_PROG2) ? prog_rdata[7:0] :
                         is_core ? core_rd :
                         data_hit ? data_rdata : 8'h00;

  // sequencer: program access takes one more cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE:  state_q <= take ? (to_prog ? S_PROG1 : S_DATA) : S_IDLE;
        S_PROG1: state_q <= S_PROG2;
        S_DATA, S_PROG2: state_q <= S_IDLE;
      endcase
    end
  end

  // latch request and addresses at acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q   <= '0;
      daddr_q <= 12'h000;
      paddr_q <= 13'h0000;
    end else if (take) begin
      req_q   <= acc;
      daddr_q <= new_daddr;
      paddr_q <= ptr_sel[PROG_AW-1:0];
    end
  end

  // answer to the datapath, one cycle after completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid_q <= 1'b0;
      resp_data_q  <= 8'h00;
    end else begin
      resp_valid_q <= done;
      if (done) resp_data_q <= rd_val;
    end
  end

  // stack push and pop, overflow and underflow
  wire push = flow.call || flow.intr_take;
  wire pop  = flow.ret && !push;
  wire ovf_ev = push && (sp_q == STK_FULL);
  wire unf_ev = pop && (sp_q == 5'h00);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q <= 5'h00;
    end else if (push && !ovf_ev) begin
      stack_q[sp_q[3:0]] <= ip_q;
      sp_q <= sp_q + 5'h01;
    end else if (pop && !unf_ev) begin
      sp_q <= sp_q - 5'h01;
    end
  end
  wire [14:0] pop_val = stack_q[sp_q[3:0] - 4'h1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ip_q <= RESET_VECTOR;
    end else if (flow.intr_take) begin
      ip_q <= INTR_VECTOR;
    end else if (flow.call || flow.jump) begin
      ip_q <= flow.target;
    end else if (pop) begin
      ip_q <= unf_ev ? RESET_VECTOR : pop_val;
    end else if (wr_core && loc == LOC_IP_LOW) begin
      ip_q <= {latch_hi_q, req_q.wdata};
    end else if (flow.advance) begin
      ip_q <= ip_q + 15'h0001;
    end
  end

  wire [2:0] alu_flags = req_q.is_sub ?
             (req_q.flag_val ^ 3'b011) : req_q.flag_val;
  // status write blocked for updated flags
  // only a data-side core write sets unmasked bits; any completed access but a clear of status, program ones too, updates masked flags
  wire [2:0] st_low = (wr_core && loc == LOC_STATUS) ?
             ((req_q.wdata[2:0] & ~req_q.flag_mask) |
              (alu_flags & req_q.flag_mask)) :
             ((status_q[2:0] & ~req_q.flag_mask) |
              (alu_flags & req_q.flag_mask));
  // clear of status: zero flag set, others kept
  wire [2:0] st_clr = {1'b1, status_q[ST_DC], status_q[ST_C]};

  // status register; upper bits always read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= STATUS_RESET;
    end else begin
      if (wr_core && req_q.clear_op && loc == LOC_STATUS) begin
        status_q[2:0] <= st_clr;
      end else if (done) begin
        status_q[2:0] <= st_low;
      end
      // expiry and sleep flags are hardware only
      if (wdt_expired) status_q[ST_TO] <= 1'b0;
      else if (wdt_cleared) status_q[ST_TO] <= 1'b1;
      if (sleep_entered) status_q[ST_PD] <= 1'b0;
      else if (wdt_cleared) status_q[ST_PD] <= 1'b1;
    end
  end

  // remaining core registers written by file access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_q     <= 5'h00;
      ptr0_q     <= 16'h0000;
      ptr1_q     <= 16'h0000;
      working_q  <= 8'h00;
      latch_hi_q <= 7'h00;
      int_ctrl_q <= 8'h00;
    end else begin
      if (wr_core && loc == LOC_BANK) bank_q <= req_q.wdata[4:0];
      if (wr_core && loc == LOC_PTR0_LO) ptr0_q[7:0] <= req_q.wdata;
      if (wr_core && loc == LOC_PTR0_HI) ptr0_q[15:8] <= req_q.wdata;
      if (wr_core && loc == LOC_PTR1_LO) ptr1_q[7:0] <= req_q.wdata;
      if (wr_core && loc == LOC_PTR1_HI) ptr1_q[15:8] <= req_q.wdata;
      if (wr_core && loc == LOC_LATCH_HI) latch_hi_q <= req_q.wdata[6:0];
      if (wr_core && loc == LOC_INT_CTRL) int_ctrl_q <= req_q.wdata;
      // program byte lands in working register
      if (done && req_q.to_working) working_q <= rd_val;
      else if (wr_core && loc == LOC_WORKING) working_q <= req_q.wdata;
    end
  end

  // axi4-lite write side: address and data taken in either order
  logic       aw_have_q, w_have_q, bvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  wire        wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire        wr_ok = (aw_addr_q == A_CTRL) || (aw_addr_q == A_STACK);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // sticky stack flags; a new event beats the clear
  wire clr_en = wr_go && aw_addr_q == A_STACK && w_strb_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_q        <= 1'b0;
      unf_q        <= 1'b0;
      stk_rst_en_q <= 1'b0;
      soft_reset_q <= 1'b0;
    end else begin
      ovf_q <= ovf_ev || (ovf_q && !(clr_en && w_data_q[0]));
      unf_q <= unf_ev || (unf_q && !(clr_en && w_data_q[1]));
      if (wr_go && aw_addr_q == A_CTRL && w_strb_q[0])
        stk_rst_en_q <= w_data_q[0];
      soft_reset_q <= stk_rst_en_q && (ovf_ev || unf_ev);
    end
  end

  // axi4-lite read side; unmapped addresses answer decode error
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  wire         ar_ok = (s_axi_araddr == A_CTRL) || (s_axi_araddr == A_STACK)
                    || (s_axi_araddr == A_IPTR) || (s_axi_araddr == A_CORE);
  wire  [31:0] ar_val =
      (s_axi_araddr == A_CTRL)  ? {31'h0, stk_rst_en_q} :
      (s_axi_araddr == A_STACK) ? {22'h0, sp_q, 3'h0, unf_q, ovf_q} :
      (s_axi_araddr == A_IPTR)  ? {17'h0, ip_q} :
      (s_axi_araddr == A_CORE)  ? {8'h0, working_q, status_q, 3'h0, bank_q} :
      32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= ar_val;
      rresp_q  <= ar_ok ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // port drive; handshake outputs combinational
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign acc_ready     = (state_q == S_IDLE);
  assign resp_valid    = resp_valid_q;
  assign resp_data     = resp_data_q;
  // fetch address aliases to 8192 words
  assign prog_addr     = (state_q == S_PROG1 || state_q == S_PROG2) ?
                         paddr_q : ip_q[PROG_AW-1:0];
  assign prog_page     = ip_q[PAGE_LSB+1:PAGE_LSB];
  assign prog_rd       = (state_q == S_PROG1);
  // array sees bank and in-bank offset past the core block
  assign data_addr     = daddr_q;
  assign data_rd       = (state_q == S_DATA) && !req_q.write && !is_core;
  assign data_wr       = (state_q == S_DATA) && req_q.write && !is_core;
  assign data_wdata    = req_q.wdata;
  assign soft_reset    = soft_reset_q;

  // properties
  sequence s_prog_take;
    take && to_prog;
  endsequence
  sequence s_prog_done;
    (state_q == S_PROG1) ##1 (state_q == S_PROG2) ##1 resp_valid;
  endsequence
  property p_prog_extra;
    @(posedge aclk) disable iff (!aresetn) s_prog_take |=> s_prog_done;
  endproperty
  a_prog_extra: assert property (p_prog_extra)
    else $error("program access not answered after three cycles");
  property p_data_two;
    @(posedge aclk) disable iff (!aresetn)
      (take && !to_prog) |=> (state_q == S_DATA) ##1 resp_valid;
  endproperty
  a_data_two: assert property (p_data_two)
    else $error("data access not answered after two cycles");
  property p_prog_byte;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_PROG2) |=> resp_data == $past(prog_rdata[7:0]);
  endproperty
  a_prog_byte: assert property (p_prog_byte)
    else $error("program read did not return the low byte");
  property p_no_prog_wr;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_PROG1 || state_q == S_PROG2) |-> !data_wr;
  endproperty
  a_no_prog_wr: assert property (p_no_prog_wr)
    else $error("write issued during program access");
  property p_intr_vec;
    @(posedge aclk) disable iff (!aresetn)
      flow.intr_take |=> ip_q == INTR_VECTOR;
  endproperty
  a_intr_vec: assert property (p_intr_vec)
    else $error("interrupt did not load vector");
  property p_bank_addr;
    @(posedge aclk) disable iff (!aresetn)
      (take && !acc.indirect) |=> data_addr == {$past(bank_q), $past(acc.file)};
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("direct address not formed from bank select");
  property p_zero_rd;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_DATA && !is_core && !data_hit) |=> resp_data == 8'h00;
  endproperty
  a_zero_rd: assert property (p_zero_rd)
    else $error("unimplemented location did not read zero");
  property p_hw_flags;
    @(posedge aclk) disable iff (!aresetn)
      (!wdt_expired && !wdt_cleared && !sleep_entered)
      |=> status_q[4:3] == $past(status_q[4:3]);
  endproperty
  a_hw_flags: assert property (p_hw_flags)
    else $error("expiry or sleep flag changed without an event");
  property p_ovf;
    @(posedge aclk) disable iff (!aresetn)
      ovf_ev |=> ovf_q && (soft_reset == $past(stk_rst_en_q));
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged");
  property p_push;
    @(posedge aclk) disable iff (!aresetn)
      (flow.call && !ovf_ev) |=> sp_q == $past(sp_q) + 5'h01;
  endproperty
  a_push: assert property (p_push)
    else $error("call did not push the stack");

endmodule : cmm_memmap
`default_nettype wire

// ### cmm_mem_model.sv
// model of the program rom and banked data ram beside the decoder
`timescale 1ns/1ns
`default_nettype none
module cmm_mem_model (
  input  wire logic        aclk,
  input  wire logic [12:0] prog_addr,
  output logic      [13:0] prog_rdata,
  input  wire logic [11:0] data_addr,
  input  wire logic        data_rd,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  output logic      [7:0]  data_rdata,
  output logic             data_hit
);
  logic [7:0] mem [4096];
  logic [7:0] last_q;
  // rom word is a pattern of its address
  assign prog_rdata = {prog_addr[5:0], ~prog_addr[7:0]};
  // upper banks absent: junk on reads, so a missing zero shows up
  assign data_hit   = ~data_addr[11];
  assign data_rdata = data_hit ? mem[data_addr] : ~last_q;
  initial begin
    last_q = 8'ha5;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'h5a;
    end
  end
  // ram write and junk update
  always @(posedge aclk) begin
    if (data_wr && data_hit) begin
      mem[data_addr] <= data_wdata;
    end
    if (data_rd) begin
      last_q <= data_rdata;
    end
  end
endmodule // cmm_mem_model
`default_nettype wire

// ### tb.sv
// self-checking bench of the cpu memory map decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cmm_pkg::*;
  typedef struct {logic [7:0] d; int lat; int tk; logic [12:0] a;} cmm_exp_t;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} cmm_ard_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, acc_ready;
  logic        resp_valid, prog_rd, data_rd, data_wr, data_hit, soft_reset;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, resp_data, data_wdata, data_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, prog_page;
  logic [12:0] prog_addr;
  logic [13:0] prog_rdata;
  logic [11:0] data_addr;
  logic [2:0]  ev;
  cmm_flow_t   flow;
  cmm_acc_t    acc;
  cmm_exp_t    rq[$];
  cmm_ard_t    aq[$];
  logic [19:0] wq[$];
  int          err_total = 0, n_compared = 0, cyc = 0, nsr = 0;
  logic [4:0]  b;
  logic [6:0]  o;
  logic [7:0]  v, lo;

  cmm_memmap cmm_memmap_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flow, .acc, .acc_ready, .resp_valid,
    .resp_data, .wdt_expired(ev[0]), .wdt_cleared(ev[1]),
    .sleep_entered(ev[2]), .prog_addr, .prog_page, .prog_rd, .prog_rdata,
    .data_addr, .data_rd, .data_wr, .data_wdata, .data_rdata, .data_hit,
    .soft_reset
  );
  cmm_mem_model cmm_mem_model_inst (
    .aclk, .prog_addr, .prog_rdata, .data_addr, .data_rd, .data_wr,
    .data_wdata, .data_rdata, .data_hit
  );

  // clock and cycle count
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // axi write: address and data offered together, each dropped once taken
  task aw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ta, tw;
    int n;
    ta = 0;
    tw = 0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw) && n < 50) begin
      @(negedge aclk);
      n++;
      ta = ta | (s_axi_awvalid & s_axi_awready);
      tw = tw | (s_axi_wvalid & s_axi_wready);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    do begin
      @(negedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 100);
    chk("bresp", r, s_axi_bresp);
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask

  // axi read: the watcher compares the data against the note
  task ar(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
    int n;
    n = 0;
    aq.push_back('{e, m, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      n++;
    end while (!s_axi_arready && n < 50);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 100);
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask

  function automatic cmm_acc_t mk(logic w, i, p, logic [6:0] f,
                                  logic [7:0] d, logic [8:0] x);
    return {1'b1, w, i, p, f, d, x};
  endfunction

  // datapath request held until taken; lat 0 means no answer noted
  task ac(input cmm_acc_t r, input logic [7:0] e, input int lat,
          input logic [12:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    acc <= r;
    @(negedge aclk);
    while (!acc_ready && n < 50) begin
      @(negedge aclk);
      n++;
    end
    if (lat > 0) rq.push_back('{e, lat, cyc, a});
    @(posedge aclk);
    acc <= '0;
  endtask

  task rdc(input logic [6:0] f, input logic [7:0] e);
    ac(mk(0, 0, 0, f, 0, 0), e, 2, 13'h1fff);
  endtask

  task wrc(input logic [6:0] f, input logic [7:0] d, input logic [8:0] x);
    ac(mk(1, 0, 0, f, d, x), 0, 0, 0);
  endtask

  task fl(input logic [4:0] k, input logic [14:0] t);
    @(posedge aclk);
    flow <= {k, t};
    @(posedge aclk);
    flow <= '0;
  endtask

  task pl(input logic [2:0] k);
    @(posedge aclk);
    ev <= k;
    @(posedge aclk);
    ev <= 0;
  endtask

  task drain;
    int n;
    n = 0;
    while ((rq.size() > 0 || aq.size() > 0) && n < 50) begin
      @(negedge aclk);
      n++;
    end
  endtask

  // watcher: outputs are settled mid-cycle; write answers are skipped
  always @(negedge aclk) begin
    if (rq.size() > 0) begin
      if (data_rd) chk("data_addr", rq[0].a, {1'b0, data_addr});
      if (prog_rd) chk("prog_addr", rq[0].a, prog_addr);
      if (resp_valid && cyc > rq[0].tk) begin
        chk("resp_data", rq[0].d, resp_data);
        chk("latency", rq[0].lat, cyc - rq[0].tk);
        void'(rq.pop_front());
      end
    end
    if (data_wr) begin
      if (wq.size() == 0) chk("data_wr", 0, 1);
      else chk("data_write", wq.pop_front(), {data_addr, data_wdata});
    end
    if (s_axi_rvalid && s_axi_rready && aq.size() > 0) begin
      chk("rdata", aq[0].d, s_axi_rdata & aq[0].m);
      chk("rresp", aq[0].r, s_axi_rresp);
      void'(aq.pop_front());
    end
    if (soft_reset) nsr++;
  end

  // hang guard
  initial begin
    repeat (4000) @(posedge aclk);
    err_total++;
    test_done;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    flow = '0;
    acc = '0;
    ev = '0;
    void'($urandom(38721));
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    // reset values, unmapped place, stack reset enable
    ar(A_IPTR, 0, '1, RESP_OKAY);
    ar(A_CORE, 32'h1800, 32'hff1f, RESP_OKAY);
    ar(8'h10, 0, '1, RESP_DECERR);
    aw(8'h10, 1, RESP_DECERR);
    aw(A_CTRL, 1, RESP_OKAY);
    // advance, call, interrupt, returns down to underflow
    repeat (3) fl(5'h10, 0);
    fl(5'h04, 15'h1234);
    fl(5'h08, 0);
    ar(A_IPTR, 4, '1, RESP_OKAY);
    ar(A_STACK, 32'h40, '1, RESP_OKAY);
    fl(5'h02, 0);
    ar(A_IPTR, 32'h1234, '1, RESP_OKAY);
    fl(5'h02, 0);
    ar(A_IPTR, 3, '1, RESP_OKAY);
    fl(5'h02, 0);
    ar(A_STACK, 2, '1, RESP_OKAY);
    aw(A_STACK, 3, RESP_OKAY);
    // the seventeenth call overflows
    repeat (17) fl(5'h04, 15'h7abc);
    ar(A_STACK, 32'h201, '1, RESP_OKAY);
    ar(A_IPTR, 32'h7abc, '1, RESP_OKAY);
    @(negedge aclk);
    chk("fetch_addr", 13'h1abc, prog_addr);
    chk("soft_reset", 2, nsr);
    fl(5'h01, 15'h0800);
    @(negedge aclk);
    chk("prog_page", 1, prog_page);
    // banked data with a random bank, offset and value
    b = 5'($urandom % 16);
    o = 7'h20 + 7'($urandom % 48);
    v = 8'($urandom);
    lo = 8'($urandom);
    wrc(LOC_BANK, {3'b0, b}, 0);
    wq.push_back({b, o, v});
    wrc(o, v, 0);
    ac(mk(0, 0, 0, o, 0, 0), v, 2, {1'b0, b, o});
    rdc(LOC_BANK, {3'b0, b});
    wrc(LOC_PTR1_HI, {4'h0, b[4:1]}, 0);
    wrc(LOC_PTR1_LO, {b[0], o}, 0);
    ac(mk(0, 1, 1, LOC_WIN0, 0, 0), v, 2, {1'b0, b, o});
    wrc(LOC_BANK, 8'd20, 0);
    ac(mk(0, 0, 0, o, 0, 0), 0, 2, {1'b0, 5'd20, o});
    // program memory through pointer 0, above the implemented size
    wrc(LOC_PTR0_HI, 8'hbf, 0);
    wrc(LOC_PTR0_LO, lo, 0);
    ac(mk(0, 1, 0, LOC_WIN0, 0, 9'h100), ~lo, 3, {5'h1f, lo});
    ac(mk(1, 1, 0, LOC_WIN0, 8'h55, 0), 0, 0, 0);
    drain;
    ar(A_CORE, {8'h0, ~lo, 8'h18, 8'd20}, 32'hffff1f, RESP_OKAY);
    // status flag masking
    wrc(LOC_STATUS, 8'hff, 0);
    rdc(LOC_STATUS, 8'h1f);
    wrc(LOC_STATUS, 0, 9'h07a);
    rdc(LOC_STATUS, 8'h1d);
    wrc(LOC_STATUS, 0, 9'h033);
    rdc(LOC_STATUS, 8'h1a);
    wrc(LOC_STATUS, 0, 9'h0c8);
    rdc(LOC_STATUS, 8'h1e);
    // hardware events move the expiry and sleep flags
    pl(3'b001);
    rdc(LOC_STATUS, 8'h0e);
    pl(3'b100);
    rdc(LOC_STATUS, 8'h06);
    pl(3'b010);
    rdc(LOC_STATUS, 8'h1e);
    drain;
    chk("pending", 0, rq.size() + aq.size());
    test_done;
  end
endmodule // tb
`default_nettype wire
